// File: design/pll_ctl_pkg.sv
`default_nettype none
package pll_ctl_pkg;
   // field selects on the host write path
   localparam logic [1:0] ADDR_REF_SEL = 2'h0;
   localparam logic [1:0] ADDR_PLL_CFG = 2'h1;
   localparam logic [1:0] ADDR_PLL_EN  = 2'h2;
   localparam logic [1:0] ADDR_LP_DIV  = 2'h3;
   // reference choices
   localparam logic       REF_SEL_TX   = 1'b0;
   localparam logic       REF_SEL_PIX  = 1'b1;
   // values after reset
   localparam logic       REF_SEL_RST  = REF_SEL_TX;
   localparam logic [7:0] PLL_CFG_RST  = 8'h00;
   localparam logic       PLL_EN_RST   = 1'b0;
   localparam logic [7:0] LP_DIV_RST   = 8'h01;
   // clock rate and times
   localparam int CLK_PERIOD_NS   = 100;
   localparam int LOCK_TIME_NS    = 100000;
   localparam int SWITCH_GAP_NS   = 200;
   localparam int SLOW_ACCESS_NS  = 1000;
   localparam int FAST_ACCESS_NS  = 200;
   // least times round up, never below one cycle
   localparam int LOCK_CYCLES  = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GAP_CYCLES   = (SWITCH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SLOW_CYCLES  = (SLOW_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FAST_CYCLES  = (FAST_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // bit clock ratios
   localparam int NIBBLE_DIV = 4;
   localparam int BYTE_DIV   = 8;
   // host commands
   typedef enum logic [2:0] {
      OP_SET_SOURCE = 3'b000,
      OP_SET_CONFIG = 3'b001,
      OP_ENABLE     = 3'b010,
      OP_SLEEP      = 3'b011,
      OP_SET_LPDIV  = 3'b100
   } host_op_t;
   // host write steps
   localparam logic [2:0] STEP_SLEEP  = 3'h0;
   localparam logic [2:0] STEP_SEL    = 3'h1;
   localparam logic [2:0] STEP_CFG    = 3'h2;
   localparam logic [2:0] STEP_EN     = 3'h3;
   localparam logic [2:0] STEP_LPDIV  = 3'h4;
endpackage : pll_ctl_pkg
`default_nettype wire

// File: design/clk_ctrl_if.sv
`default_nettype none
interface clk_ctrl_if;
   // reference clock running, driven by host
   logic       tx_clk_run;
   // field write path
   logic       wr_stb;
   logic [1:0] wr_addr;
   logic [7:0] wr_data;
   // lock indication back to host
   logic       lock_status;
   logic       lock_irq;
   modport dev  (input tx_clk_run, wr_stb, wr_addr, wr_data, output lock_status, lock_irq);
   modport host (output tx_clk_run, wr_stb, wr_addr, wr_data, input lock_status, lock_irq);
endinterface : clk_ctrl_if
`default_nettype wire

// File: design/pll_clock_reset_control.sv
`default_nettype none
// Function
// RL1 - reference select resets to external reference
// RL2 - host picks reference by select write
// RL3 - host keeps reference running after power-up
// RL4 - reference may stop only after select written
// RL5 - pll sleeps after reset until enabled
// RL6 - host writes config before enabling pll
// RL7 - sleep, reprogram, re-enable around source change
// RL8 - system runs on reference until lock
// RL9 - system moves to pll output on lock
// RL10 - host accesses slowly until lock
// RL11 - lock drives an interrupt source
// RL12 - lock status bit readable by host
// RL13 - pll rate equals one lane rate
// RL14 - bit clock sources every other clock
// RL15 - nibble clock is bit clock over four
// RL16 - byte clock is bit clock over eight
// RL17 - low-power clock is byte clock divided
// RL18 - low-power period equals two lpx intervals; a divider of zero or one gives one lpx per period
// RL19 - system clock switch without truncated pulses
module pll_clock_reset_control #(
   parameter int LOCK_CNT = pll_ctl_pkg::LOCK_CYCLES
) (
   // clock and reset
   input  wire logic   ref_clk,
   input  wire logic   srst,
   // link to host
   clk_ctrl_if.dev     ctl,
   // reference presence
   input  wire logic   pix_clk_present,
   // system clock selection
   output logic        sys_on_pll,
   output logic        sys_clk_gate,
   // derived clock enables
   output logic        bit_tick,
   output logic        nibble_tick,
   output logic        byte_tick,
   output logic        lpx_tick,
   output logic        lp_tick,
   // programmed pll state
   output logic        pll_enabled,
   output logic        ref_source_select,
   output logic [7:0]  pll_config
);
   import pll_ctl_pkg::*;

   typedef enum logic [1:0] {
      SYS_REF    = 2'b00,
      SYS_TO_PLL = 2'b01,
      SYS_PLL    = 2'b10,
      SYS_TO_REF = 2'b11
   } sys_state_t;

   localparam int LCW = $clog2(LOCK_CNT + 1);
   localparam int GCW = $clog2(GAP_CYCLES + 1);

   logic             ref_sel_r, ref_sel_nxt;
   logic [7:0]       cfg_r, cfg_nxt;
   logic             en_r, en_nxt;
   logic [7:0]       lpd_r, lpd_nxt;
   logic [LCW-1:0]   lock_cnt_r, lock_cnt_nxt;
   logic             lock_r, lock_nxt;
   sys_state_t       sys_r, sys_nxt;
   logic [GCW-1:0]   gap_r, gap_nxt;
   logic             on_pll_r, on_pll_nxt;
   logic             gate_r, gate_nxt;
   logic [2:0]       div8_r, div8_nxt;
   logic             bit_r, bit_nxt;
   logic             nib_r, nib_nxt;
   logic             byt_r, byt_nxt;
   logic [7:0]       lp_cnt_r, lp_cnt_nxt;
   logic             lpx_r, lpx_nxt;
   logic             lp_r, lp_nxt;
   logic             ref_ok;
   logic             wr_ok;
   logic [7:0]       lp_div_eff;

   // selected reference is running
   assign ref_ok = (ref_sel_r == REF_SEL_TX) ? ctl.tx_clk_run : pix_clk_present;
   // RL3 writes need reference
   assign wr_ok  = ctl.wr_stb && ctl.tx_clk_run;

   // field writes
   always_comb begin
      ref_sel_nxt = ref_sel_r;
      cfg_nxt     = cfg_r;
      en_nxt      = en_r;
      lpd_nxt     = lpd_r;
      if (wr_ok) begin
         unique case (ctl.wr_addr)
            // RL2 reference choice
            ADDR_REF_SEL: ref_sel_nxt = ctl.wr_data[0];
            ADDR_PLL_CFG: cfg_nxt     = ctl.wr_data;
            ADDR_PLL_EN:  en_nxt      = ctl.wr_data[0];
            ADDR_LP_DIV:  lpd_nxt     = ctl.wr_data;
         endcase
      end
   end

   // RL1 RL5 reset values
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ref_sel_r <= REF_SEL_RST;
         cfg_r     <= PLL_CFG_RST;
         en_r      <= PLL_EN_RST;
         lpd_r     <= LP_DIV_RST;
      end else begin
         ref_sel_r <= ref_sel_nxt;
         cfg_r     <= cfg_nxt;
         en_r      <= en_nxt;
         lpd_r     <= lpd_nxt;
      end
   end

   // lock model: any write to the pll fields restarts acquisition
   always_comb begin
      lock_cnt_nxt = lock_cnt_r;
      lock_nxt     = lock_r;
      if (!en_r || !ref_ok || (wr_ok && ctl.wr_addr != ADDR_LP_DIV)) begin
         lock_cnt_nxt = '0;
         lock_nxt     = 1'b0;
      end else if (lock_cnt_r == LCW'(LOCK_CNT)) begin
         lock_nxt = 1'b1;
      end else begin
         lock_cnt_nxt = lock_cnt_r + LCW'(1);
      end
   end
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         lock_cnt_r <= '0;
         lock_r     <= 1'b0;
      end else begin
         lock_cnt_r <= lock_cnt_nxt;
         lock_r     <= lock_nxt;
      end
   end

   // system clock source; gate stays low across the gap so no short pulse leaks
   always_comb begin
      sys_nxt    = sys_r;
      gap_nxt    = gap_r;
      on_pll_nxt = on_pll_r;
      gate_nxt   = gate_r;
      unique case (sys_r)
         // RL8 run on reference
         SYS_REF: begin
            if (lock_r) begin
               sys_nxt  = SYS_TO_PLL;
               gate_nxt = 1'b0;
               gap_nxt  = '0;
            end
         end
         // RL19 quiet gap then switch
         SYS_TO_PLL: begin
            if (!lock_r) begin
               sys_nxt  = SYS_REF;
               gate_nxt = 1'b1;
            end else if (gap_r == GCW'(GAP_CYCLES)) begin
               // RL9 move to pll
               sys_nxt    = SYS_PLL;
               on_pll_nxt = 1'b1;
               gate_nxt   = 1'b1;
            end else begin
               gap_nxt = gap_r + GCW'(1);
            end
         end
         SYS_PLL: begin
            if (!lock_r) begin
               sys_nxt  = SYS_TO_REF;
               gate_nxt = 1'b0;
               gap_nxt  = '0;
            end
         end
         // RL19 quiet gap back to reference
         SYS_TO_REF: begin
            if (gap_r == GCW'(GAP_CYCLES)) begin
               sys_nxt    = SYS_REF;
               on_pll_nxt = 1'b0;
               gate_nxt   = 1'b1;
            end else begin
               gap_nxt = gap_r + GCW'(1);
            end
         end
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sys_r    <= SYS_REF;
         gap_r    <= '0;
         on_pll_r <= 1'b0;
         gate_r   <= 1'b1;
      end else begin
         sys_r    <= sys_nxt;
         gap_r    <= gap_nxt;
         on_pll_r <= on_pll_nxt;
         gate_r   <= gate_nxt;
      end
   end

   // zero divider would stall the low-power clock, so treat it as one
   assign lp_div_eff = (lpd_r == 8'h00) ? 8'h01 : lpd_r;

   // derived clock enables, all counted from bit ticks
   always_comb begin
      // RL13 RL14 bit tick is the pll rate
      bit_nxt    = on_pll_r && gate_r;
      div8_nxt   = div8_r;
      nib_nxt    = 1'b0;
      byt_nxt    = 1'b0;
      lp_cnt_nxt = lp_cnt_r;
      lpx_nxt    = 1'b0;
      lp_nxt     = 1'b0;
      if (!bit_nxt) begin
         div8_nxt   = '0;
         lp_cnt_nxt = '0;
      end else begin
         div8_nxt = div8_r + 3'h1;
         // RL15 every fourth bit
         nib_nxt  = (div8_r[1:0] == 2'(NIBBLE_DIV - 1));
         // RL16 every eighth bit
         byt_nxt  = (div8_r == 3'(BYTE_DIV - 1));
         if (byt_nxt) begin
            // RL17 divide byte ticks
            if (lp_cnt_r == lp_div_eff - 8'h01) begin
               lp_cnt_nxt = '0;
               lp_nxt     = 1'b1;
               lpx_nxt    = 1'b1;
            end else begin
               lp_cnt_nxt = lp_cnt_r + 8'h01;
            end
            // RL18 second lpx at half period
            if (lp_cnt_r == (lp_div_eff >> 1) - 8'h01 && lp_div_eff > 8'h01) begin
               lpx_nxt = 1'b1;
            end
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         bit_r    <= 1'b0;
         div8_r   <= '0;
         nib_r    <= 1'b0;
         byt_r    <= 1'b0;
         lp_cnt_r <= '0;
         lpx_r    <= 1'b0;
         lp_r     <= 1'b0;
      end else begin
         bit_r    <= bit_nxt;
         div8_r   <= div8_nxt;
         nib_r    <= nib_nxt;
         byt_r    <= byt_nxt;
         lp_cnt_r <= lp_cnt_nxt;
         lpx_r    <= lpx_nxt;
         lp_r     <= lp_nxt;
      end
   end

   // RL12 lock status readable
   assign ctl.lock_status = lock_r;
   // RL11 lock as interrupt source
   assign ctl.lock_irq    = lock_r;
   assign sys_on_pll        = on_pll_r;
   assign sys_clk_gate      = gate_r;
   assign bit_tick          = bit_r;
   assign nibble_tick       = nib_r;
   assign byte_tick         = byt_r;
   assign lpx_tick          = lpx_r;
   assign lp_tick           = lp_r;
   assign pll_enabled       = en_r;
   assign ref_source_select = ref_sel_r;
   assign pll_config        = cfg_r;
endmodule : pll_clock_reset_control
`default_nettype wire

// File: design/pll_host_ctrl.sv
`default_nettype none
module pll_host_ctrl (
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 srst,
   // link to device
   clk_ctrl_if.host                  ctl,
   // user commands
   input  wire logic                 cmd_valid,
   input  wire pll_ctl_pkg::host_op_t cmd_op,
   input  wire logic [7:0]           cmd_data,
   output logic                      cmd_ready,
   input  wire logic                 stop_tx_clk_req,
   // user status
   output logic                      locked
);
   import pll_ctl_pkg::*;

   localparam int WCW = $clog2(SLOW_CYCLES + 1);

   logic           busy_r, busy_nxt;
   logic [2:0]     step_r, step_nxt;
   logic [2:0]     last_r, last_nxt;
   logic [WCW-1:0] wait_r, wait_nxt;
   logic           src_r, src_nxt;
   logic [7:0]     cfg_r, cfg_nxt;
   logic [7:0]     lpd_r, lpd_nxt;
   logic           stb_r, stb_nxt;
   logic [1:0]     addr_r, addr_nxt;
   logic [7:0]     data_r, data_nxt;
   logic           run_r, run_nxt;
   logic           lock_r;

   // field and value for one step of a sequence
   function automatic logic [9:0] step_write(input logic [2:0] s, input logic src,
                                             input logic [7:0] cfg, input logic [7:0] lp_clock_divider);
      unique case (s)
         STEP_SLEEP: step_write = {ADDR_PLL_EN, 8'h00};
         STEP_SEL:   step_write = {ADDR_REF_SEL, 7'h00, src};
         STEP_CFG:   step_write = {ADDR_PLL_CFG, cfg};
         STEP_EN:    step_write = {ADDR_PLL_EN, 8'h01};
         default:    step_write = {ADDR_LP_DIV, lp_clock_divider};
      endcase
   endfunction : step_write

   // sequencer: one write, then a wait sized by lock state
   always_comb begin
      busy_nxt = busy_r;
      step_nxt = step_r;
      last_nxt = last_r;
      wait_nxt = wait_r;
      src_nxt  = src_r;
      cfg_nxt  = cfg_r;
      lpd_nxt  = lpd_r;
      stb_nxt  = 1'b0;
      addr_nxt = addr_r;
      data_nxt = data_r;
      if (!busy_r && cmd_valid) begin
         busy_nxt = 1'b1;
         wait_nxt = '0;
         unique case (cmd_op)
            // RL7 sleep, select, program, enable
            OP_SET_SOURCE: begin
               src_nxt  = cmd_data[0];
               step_nxt = STEP_SLEEP;
               last_nxt = STEP_EN;
            end
            OP_SET_CONFIG: begin
               cfg_nxt  = cmd_data;
               step_nxt = STEP_CFG;
               last_nxt = STEP_CFG;
            end
            // RL6 config goes out before enable
            OP_ENABLE: begin
               step_nxt = STEP_CFG;
               last_nxt = STEP_EN;
            end
            OP_SLEEP: begin
               step_nxt = STEP_SLEEP;
               last_nxt = STEP_SLEEP;
            end
            default: begin
               lpd_nxt  = cmd_data;
               step_nxt = STEP_LPDIV;
               last_nxt = STEP_LPDIV;
            end
         endcase
      end else if (busy_r) begin
         if (wait_r == '0) begin
            stb_nxt = 1'b1;
            {addr_nxt, data_nxt} = step_write(step_r, src_r, cfg_r, lpd_r);
            wait_nxt = WCW'(1);
         // delayed lock alone lets one fast write slip out after a lock loss
         end else if ((lock_r && ctl.lock_status && wait_r >= WCW'(FAST_CYCLES)) ||
                      wait_r >= WCW'(SLOW_CYCLES)) begin
            // RL10 slow spacing until lock
            wait_nxt = '0;
            if (step_r == last_r) begin
               busy_nxt = 1'b0;
            end else begin
               step_nxt = step_r + 3'h1;
            end
         end else begin
            wait_nxt = wait_r + WCW'(1);
         end
      end
   end

   // RL3 RL4 reference stops only when idle on pixel source
   assign run_nxt = !(stop_tx_clk_req && !busy_r && src_r == REF_SEL_PIX);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         busy_r <= 1'b0;
         step_r <= STEP_SLEEP;
         last_r <= STEP_SLEEP;
         wait_r <= '0;
         src_r  <= REF_SEL_RST;
         cfg_r  <= PLL_CFG_RST;
         lpd_r  <= LP_DIV_RST;
         stb_r  <= 1'b0;
         addr_r <= 2'h0;
         data_r <= 8'h00;
         run_r  <= 1'b1;
         lock_r <= 1'b0;
      end else begin
         busy_r <= busy_nxt;
         step_r <= step_nxt;
         last_r <= last_nxt;
         wait_r <= wait_nxt;
         src_r  <= src_nxt;
         cfg_r  <= cfg_nxt;
         lpd_r  <= lpd_nxt;
         stb_r  <= stb_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         run_r  <= run_nxt;
         lock_r <= ctl.lock_status;
      end
   end

   assign ctl.tx_clk_run = run_r;
   assign ctl.wr_stb     = stb_r;
   assign ctl.wr_addr    = addr_r;
   assign ctl.wr_data    = data_r;
   assign cmd_ready      = !busy_r;
   assign locked         = lock_r;
endmodule : pll_host_ctrl
`default_nettype wire

// File: bench/pll_clock_reset_control_checker.sv
`default_nettype none
module pll_clock_reset_control_checker #(
   parameter int LOCK_CNT = 20
) (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       srst,
   // link signals
   input wire logic       tx_clk_run,
   input wire logic       wr_stb,
   input wire logic [1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic       lock_status,
   input wire logic       lock_irq
);
   timeunit 1ns;
   timeprecision 100ps;
   import pll_ctl_pkg::*;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   // slack of a few cycles over the lock count
   localparam int LOCK_LATE = LOCK_CNT + 4;
   logic        sel_r;
   logic        sel_nxt;
   logic        en_r;
   logic        en_nxt;
   logic        cfg_r;
   logic        cfg_nxt;
   logic [15:0] wait_r;
   logic [15:0] wait_nxt;
   logic        wr_ok;
   logic        pll_wr;
   assign wr_ok  = wr_stb && tx_clk_run;
   assign pll_wr = wr_ok && (wr_addr != ADDR_LP_DIV);
   // shadow of accepted writes; wait count saturates instead of wrapping
   always_comb begin
      sel_nxt  = sel_r;
      en_nxt   = en_r;
      cfg_nxt  = cfg_r;
      wait_nxt = (wait_r == 16'hffff) ? wait_r : wait_r + 16'h0001;
      if (pll_wr) begin
         wait_nxt = 16'h0000;
      end
      if (wr_ok && wr_addr == ADDR_REF_SEL) begin
         sel_nxt = wr_data[0];
         cfg_nxt = 1'b0;   // a new source needs a fresh config
      end
      if (wr_ok && wr_addr == ADDR_PLL_CFG) begin
         cfg_nxt = 1'b1;
      end
      if (wr_ok && wr_addr == ADDR_PLL_EN) begin
         en_nxt = wr_data[0];
      end
      if (srst) begin
         sel_nxt  = REF_SEL_RST;
         en_nxt   = PLL_EN_RST;
         cfg_nxt  = 1'b0;
         wait_nxt = 16'h0000;
      end
   end
   always_ff @(posedge ref_clk) begin
      {sel_r, en_r, cfg_r, wait_r} <= {sel_nxt, en_nxt, cfg_nxt, wait_nxt};
   end
   // quiet spans
   sequence s_quiet;
      !wr_stb [*8];
   endsequence
   sequence s_unlocked;
      !lock_status [*8];
   endsequence
   property p_irq_follows;
      lock_irq == lock_status;
   endproperty
   property p_rst_quiet;
      @(posedge ref_clk) disable iff (1'b0) srst |=> !lock_status && tx_clk_run && !wr_stb;
   endproperty
   property p_sleep_unlocked;
      !en_r |-> !lock_status;
   endproperty
   property p_wr_clears_lock;
      pll_wr |=> s_unlocked;
   endproperty
   property p_lock_not_early;
      $rose(lock_status) |-> wait_r >= LOCK_CNT;
   endproperty
   property p_lock_in_time;
      en_r && sel_r == REF_SEL_TX && tx_clk_run && wait_r == LOCK_LATE |-> lock_status;
   endproperty
   property p_cfg_before_en;
      wr_ok && wr_addr == ADDR_PLL_EN && wr_data[0] |-> cfg_r;
   endproperty
   property p_sel_in_sleep;
      wr_ok && wr_addr == ADDR_REF_SEL |-> !en_r;
   endproperty
   // a pll write drops lock, so the write after it must come slowly too
   property p_slow_spacing;
      wr_stb && (pll_wr || !lock_status) |=> s_quiet;
   endproperty
   property p_stop_only_pix;
      $fell(tx_clk_run) |-> sel_r == REF_SEL_PIX && !wr_stb;
   endproperty
   a_irq_follows: assert property (p_irq_follows)
      else $error("lock interrupt differs from lock status");
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("link not quiet after reset");
   a_sleep_unlocked: assert property (p_sleep_unlocked)
      else $error("lock while pll disabled");
   a_wr_clears_lock: assert property (p_wr_clears_lock)
      else $error("lock not cleared by pll write");
   a_lock_not_early: assert property (p_lock_not_early)
      else $error("lock came too early");
   a_lock_in_time: assert property (p_lock_in_time)
      else $error("lock missing after enable");
   a_cfg_before_en: assert property (p_cfg_before_en)
      else $error("enable without config");
   a_sel_in_sleep: assert property (p_sel_in_sleep)
      else $error("source changed while enabled");
   a_slow_spacing: assert property (p_slow_spacing)
      else $error("writes too close before lock");
   a_stop_only_pix: assert property (p_stop_only_pix)
      else $error("reference stopped while needed");
endmodule : pll_clock_reset_control_checker
`default_nettype wire

// File: bench/pll_clock_reset_control_tb.sv
`default_nettype none
module pll_clock_reset_control_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import pll_ctl_pkg::*;
   localparam int LOCK_SIM = 20;
   typedef struct {
      host_op_t   op;
      logic [7:0] d;
      logic       sel;
      logic [7:0] cfg;
      logic       en;
      logic       lk;
   } row_t;
   logic       ref_clk;
   logic       srst;
   logic       pix_clk_present;
   logic       cmd_valid;
   host_op_t   cmd_op;
   logic [7:0] cmd_data;
   logic       cmd_ready;
   logic       stop_tx_clk_req;
   logic       sys_on_pll;
   logic       sys_clk_gate;
   logic       bit_tick;
   logic [3:0] ticks;   // lp, lpx, byte, nibble
   logic       pll_enabled;
   logic       ref_source_select;
   logic [7:0] pll_config;
   logic       locked;
   logic       on_q;
   logic       gate_q;
   int         err_count;
   int         tests_run;
   row_t       rows [5];
   clk_ctrl_if i_clk_ctrl_if ();
   pll_clock_reset_control #(.LOCK_CNT(LOCK_SIM)) i_pll_clock_reset_control (
      .ref_clk(ref_clk), .srst(srst), .ctl(i_clk_ctrl_if), .pix_clk_present(pix_clk_present),
      .sys_on_pll(sys_on_pll), .sys_clk_gate(sys_clk_gate), .bit_tick(bit_tick),
      .nibble_tick(ticks[0]), .byte_tick(ticks[1]), .lpx_tick(ticks[2]), .lp_tick(ticks[3]),
      .pll_enabled(pll_enabled), .ref_source_select(ref_source_select),
      .pll_config(pll_config));
   pll_host_ctrl i_pll_host_ctrl (
      .ref_clk(ref_clk), .srst(srst), .ctl(i_clk_ctrl_if), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
      .stop_tx_clk_req(stop_tx_clk_req), .locked(locked));
   pll_clock_reset_control_checker #(.LOCK_CNT(LOCK_SIM)) i_pll_clock_reset_control_checker (
      .ref_clk(ref_clk), .srst(srst), .tx_clk_run(i_clk_ctrl_if.tx_clk_run),
      .wr_stb(i_clk_ctrl_if.wr_stb), .wr_addr(i_clk_ctrl_if.wr_addr),
      .wr_data(i_clk_ctrl_if.wr_data), .lock_status(i_clk_ctrl_if.lock_status),
      .lock_irq(i_clk_ctrl_if.lock_irq));
   // free-running reference, 100 ns
   always #50 ref_clk = ~ref_clk;
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chkn(input int got, input int exp);
      tests_run++;
      if (got != exp) begin
         err_count++;
         $display("ERROR at %0t: count %0d expected %0d", $time, got, exp);
      end
   endtask : chkn
   task automatic results();
      $display("errors %0d, checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results
   // one command, held until taken, then wait for idle
   task automatic send(input host_op_t op, input logic [7:0] d);
      int k;
      for (k = 0; k < 50 && cmd_ready !== 1'b1; k++) tick();
      cmd_op    = op;
      cmd_data  = d;
      cmd_valid = 1'b1;
      tick();
      cmd_valid = 1'b0;
      for (k = 0; k < 300 && cmd_ready !== 1'b1; k++) tick();
      chk(cmd_ready, 1'b1);
   endtask : send
   task automatic wait_on(input logic exp);
      int k;
      for (k = 0; k < 100 && sys_on_pll !== exp; k++) tick();
      chk(sys_on_pll, exp);
      chk(i_clk_ctrl_if.lock_status, exp);
      chk(locked, exp);
   endtask : wait_on
   // cycles between two pulses of one tick output
   task automatic gap(input int idx, output int n);
      int k;
      int t0;
      t0 = -1;
      n  = 0;
      for (k = 0; k < 300; k++) begin
         tick();
         if (ticks[idx] === 1'b1 && t0 >= 0) begin
            n = k - t0;
            break;
         end
         if (ticks[idx] === 1'b1) begin
            t0 = k;
         end
      end
   endtask : gap
   task automatic rst_chk();
      chk(ref_source_select, REF_SEL_RST);
      chk(pll_enabled, PLL_EN_RST);
      chk(pll_config, PLL_CFG_RST);
      chk({sys_on_pll, sys_clk_gate, i_clk_ctrl_if.lock_status}, 8'h02);
   endtask : rst_chk
   // the system clock may change source only inside a gated gap
   always @(negedge ref_clk) begin
      if (srst === 1'b0 && sys_on_pll !== on_q) begin
         chk(gate_q, 1'b0);
      end
      on_q   <= sys_on_pll;
      gate_q <= sys_clk_gate;
   end
   // watchdog, far beyond the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      results();
   end
   initial begin
      int n;
      int i;
      ref_clk         = 1'b0;
      srst            = 1'b1;
      pix_clk_present = 1'b1;
      cmd_valid       = 1'b0;
      cmd_op          = OP_SLEEP;
      cmd_data        = 8'h00;
      stop_tx_clk_req = 1'b0;
      err_count       = 0;
      tests_run       = 0;
      // enable resends the stored config; its own data byte is ignored
      rows = '{'{OP_SET_CONFIG, 8'h3c, 1'b0, 8'h3c, 1'b0, 1'b0},
               '{OP_ENABLE,     8'h5a, 1'b0, 8'h3c, 1'b1, 1'b1},
               '{OP_SLEEP,      8'h00, 1'b0, 8'h3c, 1'b0, 1'b0},
               '{OP_SET_LPDIV,  8'h04, 1'b0, 8'h3c, 1'b0, 1'b0},
               '{OP_SET_SOURCE, 8'h01, 1'b1, 8'h3c, 1'b1, 1'b1}};
      repeat (8) @(posedge ref_clk);
      #1;
      srst = 1'b0;
      rst_chk();
      foreach (rows[r]) begin
         send(rows[r].op, rows[r].d);
         wait_on(rows[r].lk);
         chk(ref_source_select, rows[r].sel);
         chk(pll_config, rows[r].cfg);
         chk(pll_enabled, rows[r].en);
         chk(i_clk_ctrl_if.lock_irq, rows[r].lk);
      end
      // divided ticks with the low-power divider at four; bit tick trails the switch
      tick();
      chk(bit_tick, 1'b1);
      for (i = 0; i < 4; i++) begin
         gap(i, n);
         chkn(n, 4 << i);
      end
      // pixel clock chosen, so the external reference may stop
      stop_tx_clk_req = 1'b1;
      for (i = 0; i < 40 && i_clk_ctrl_if.tx_clk_run !== 1'b0; i++) tick();
      chk(i_clk_ctrl_if.tx_clk_run, 1'b0);
      chk(i_clk_ctrl_if.lock_status, 1'b1);
      stop_tx_clk_req = 1'b0;
      for (i = 0; i < 40 && i_clk_ctrl_if.tx_clk_run !== 1'b1; i++) tick();
      chk(i_clk_ctrl_if.tx_clk_run, 1'b1);
      // losing the selected reference falls back, then relocks
      pix_clk_present = 1'b0;
      wait_on(1'b0);
      pix_clk_present = 1'b1;
      wait_on(1'b1);
      // enable again while locked: the config write drops lock, later writes go slow
      send(OP_ENABLE, 8'h00);
      wait_on(1'b1);
      // reset in mid-run while locked
      srst = 1'b1;
      repeat (2) tick();
      srst = 1'b0;
      rst_chk();
      results();
   end
endmodule : pll_clock_reset_control_tb
`default_nettype wire
